/* File: src/pgm_regs.svh */
`ifndef PGM_REGS_SVH
`define PGM_REGS_SVH
// register byte offsets
`define PGM_A_FLAGS     12'h000
`define PGM_A_MASKS     12'h004
`define PGM_A_STATUS    12'h008
`define PGM_A_CTRL      12'h00C
`define PGM_A_FAULT     12'h010
`define PGM_A_RESET     12'h014
// flag bit positions (flag register)
`define PGM_F_BUCK0     0
`define PGM_F_BUCK1     1
`define PGM_F_BUCKSUM   2
`define PGM_F_LDO0      3
`define PGM_F_LDO1      4
`define PGM_F_LDOSUM    5
`define PGM_F_PVDROP    6
`define PGM_F_SYNC      7
`define PGM_F_MEAS      8
`define PGM_F_RESET     9
`define PGM_F_OVP       10
`define PGM_F_TSD       11
`define PGM_NFLAG       12
// mask register: fall masks 0..3, rise masks 4..7, others 8..11
`define PGM_M_FALL      0
`define PGM_M_RISE      4
`define PGM_M_PVDROP    8
`define PGM_M_SYNC      9
`define PGM_M_MEAS      10
`define PGM_M_RESET     11
// ctrl register fields
`define PGM_C_SEL       0
`define PGM_C_TWSEL     4
`define PGM_C_WIN       5
`define PGM_C_POL       9
`define PGM_C_OD        10
`define PGM_C_MODE      11
`define PGM_C_FGATE     12
`define PGM_C_RESET_VAL 32'h0000_020F
// status fields
`define PGM_S_RAIL      0
`define PGM_S_PV        4
`define PGM_S_SYNC      5
`define PGM_S_TWARN     6
// timing
`define PGM_GATE_US     800
`define PGM_CLK_MHZ     50
`endif

/* File: src/pgm_pkg.sv */
package pgm_pkg;
    typedef enum logic [1:0] {
        PGM_LOAD  = 2'b00,  // configuration load after reset
        PGM_RUN   = 2'b01,  // normal monitoring
        PGM_GATED = 2'b10   // gated hold period
    } pgm_state_t;
endpackage

/* File: src/pgm_edge_flag.sv */
`include "pgm_regs.svh"
// sticky flag set by event, cleared by write-one; set wins over clear
module pgm_edge_flag (
    input  wire logic clk,     // system clock
    input  wire logic srst,    // sync reset
    input  wire logic set_i,   // event pulse
    input  wire logic clr_i,   // write-one clear pulse
    output logic      flag_o   // sticky flag
);
    // set has priority so an event in the clear cycle survives
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule // pgm_edge_flag

/* File: src/pgm_power_good.sv */
`include "pgm_regs.svh"
// Contract
// R1: buck invalid edge sets flags unless masked
// R2: linreg edges set flags, rise/fall masks
// R3: power-valid drop sets flag unless masked
// R4: status is internal valid; polarity pin only
// R5: sync clock change sets flag, status shown
// R6: missing clock raises sync flag when enabled
// R7: measurement ready sets flag, no status
// R8: supply lockout resets all, no flag
// R9: supply up: defaults, load, flag unless masked
// R10: soft reset restarts, sets reset flag
// R11: selectable sources, disabled rails masked
// R12: valid only when all sources valid
// R13: window bit adds overvoltage check
// R14: polarity and open-drain select
// R15: mode bit gated/continuous, strap default
// R16: gated: assert, hold 800us after changes
// R17: gated faults latch, block monitoring
// R18: host clears faults by writing one
// R19: continuous: drop on enable, then follow
// R20: fault bits latch until written one
// R21: inactive while rail voltage ramps
// R22: fault gating holds output inactive
// R23: reset mask from strap, writes ignored
// R24: write zero no effect; irq while pending
module pgm_power_good #(
    parameter int NRAIL    = 4,       // buck0, buck1, linreg0, linreg1
    parameter int GATE_CYC = `PGM_GATE_US * `PGM_CLK_MHZ  // gated hold cycles
) (
    input  wire logic              clk,              // 50 MHz clock
    input  wire logic              srst,             // sync reset
    input  wire logic              psel,             // apb select
    input  wire logic              penable,          // apb enable
    input  wire logic              pwrite,           // apb write
    input  wire logic [11:0]       paddr,            // apb byte address
    input  wire logic [31:0]       pwdata,           // apb write data
    output logic      [31:0]       prdata,           // apb read data
    output logic                   pready,           // apb ready
    output logic                   pslverr,          // apb error
    input  wire logic              analog_supply_ok, // supply above lockout (pin)
    input  wire logic              mode_strap,       // otp mode default
    input  wire logic              reset_mask_strap, // otp reset-flag mask
    input  wire logic [NRAIL-1:0]  rail_enable,      // regulator enabled
    input  wire logic [NRAIL-1:0]  rail_under_ok,    // above undervolt (pin)
    input  wire logic [NRAIL-1:0]  rail_over_ok,     // below overvolt (pin)
    input  wire logic [NRAIL-1:0]  rail_ramping,     // target change in progress
    input  wire logic              volt_change_req,  // pulse: requested change
    input  wire logic              thermal_warn_in,  // thermal warning (pin)
    input  wire logic              overvolt_in,      // input overvoltage (pin)
    input  wire logic              thermal_sd_in,    // thermal shutdown (pin)
    input  wire logic              clk_det_enable,   // clock detector enabled
    input  wire logic              sync_clk_present, // ext clock seen (pin)
    input  wire logic              meas_done,        // pulse: measurement done
    output logic                   power_valid_out,  // pin data
    output logic                   power_valid_oe,   // pin drive enable
    output logic                   irq_line_low,     // interrupt, active low
    output logic                   soft_reset_req    // pulse: restart request
);
    localparam int GW = $clog2(GATE_CYC + 1);  // gate counter width

    // two-flop synchronisers for asynchronous inputs
    localparam int NS = 3 * NRAIL + 5;
    logic [NS-1:0] sy1_r, sy2_r;
    always_ff @(posedge clk) begin
        sy1_r <= {rail_under_ok, rail_over_ok, rail_ramping, thermal_warn_in,
                  overvolt_in, thermal_sd_in, sync_clk_present, analog_supply_ok};
        sy2_r <= sy1_r;
    end
    logic [NRAIL-1:0] uv_ok, ov_ok, ramp;
    logic             twarn, ovp, tsd, sclk, supply_ok;
    assign {uv_ok, ov_ok, ramp, twarn, ovp, tsd, sclk, supply_ok} = sy2_r;

    // combined reset: bus reset, lockout or software restart
    logic supply_ok_q_r, swrst_r;
    // R8: lockout resets everything
    wire  rst_all = srst | ~supply_ok | swrst_r;
    always_ff @(posedge clk) begin
        if (srst) supply_ok_q_r <= 1'b0;
        else      supply_ok_q_r <= supply_ok;
    end
    assign soft_reset_req = swrst_r;

    // apb: zero wait, access phase answers at once
    wire acc = psel & penable;
    wire wr  = acc & pwrite;
    assign pready  = 1'b1;
    // unmapped offsets answer with an error
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `PGM_A_FLAGS) | (a == `PGM_A_MASKS) | (a == `PGM_A_STATUS) |
                 (a == `PGM_A_CTRL) | (a == `PGM_A_FAULT) | (a == `PGM_A_RESET);
    endfunction
    assign pslverr = acc & ~mapped(paddr);
    wire wr_flag  = wr & (paddr == `PGM_A_FLAGS);
    wire wr_fault = wr & (paddr == `PGM_A_FAULT);

    // software restart pulse, auto-clearing
    always_ff @(posedge clk) begin
        if (srst) begin
            swrst_r <= 1'b0;
        end else begin
            // R10: soft reset request
            swrst_r <= wr & (paddr == `PGM_A_RESET) & pwdata[0];
        end
    end

    // mask and control registers
    logic [11:0] mask_r;
    logic [31:0] ctrl_r;
    logic        reset_mask_r;   // loaded only from strap
    logic        load_r;         // first cycle after reset release
    always_ff @(posedge clk) begin
        if (rst_all) begin
            mask_r <= 12'h000;
            ctrl_r <= `PGM_C_RESET_VAL;
            load_r <= 1'b1;
        end else begin
            load_r <= 1'b0;
            if (load_r) begin
                // R15: mode default from strap
                ctrl_r[`PGM_C_MODE] <= mode_strap;
            end else if (wr & (paddr == `PGM_A_CTRL)) begin
                ctrl_r <= {19'h0, pwdata[12:0]};
            end
            if (wr & (paddr == `PGM_A_MASKS)) mask_r <= pwdata[11:0];
        end
    end
    // R23: reset mask comes only from the strap
    always_ff @(posedge clk) begin
        if (srst) reset_mask_r <= 1'b0;
        else if (load_r) reset_mask_r <= reset_mask_strap;
    end

    // per-rail goodness; R13: window adds overvoltage check
    logic [NRAIL-1:0] rail_good, rail_good_q_r, rail_sel;
    genvar g;
    generate
        for (g = 0; g < NRAIL; g++) begin : g_rail
            assign rail_good[g] = uv_ok[g] & (ov_ok[g] | ~ctrl_r[`PGM_C_WIN + g]);
            // R11: disabled regulator masked automatically
            assign rail_sel[g]  = ctrl_r[`PGM_C_SEL + g] & rail_enable[g];
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (rst_all) rail_good_q_r <= '0;
        else         rail_good_q_r <= rail_good;
    end
    wire [NRAIL-1:0] rise = rail_good & ~rail_good_q_r;
    wire [NRAIL-1:0] fall = ~rail_good & rail_good_q_r;

    // event set terms for each flag
    logic [`PGM_NFLAG-1:0] set_v, flag_v;
    logic sclk_q_r, pv_r, pv_q_r, boot_r;
    always_comb begin
        set_v = '0;
        // R1: buck invalid edges, fall mask
        set_v[`PGM_F_BUCK0] = fall[0] & ~mask_r[`PGM_M_FALL];
        set_v[`PGM_F_BUCK1] = fall[1] & ~mask_r[`PGM_M_FALL + 1];
        set_v[`PGM_F_BUCKSUM] = set_v[`PGM_F_BUCK0] | set_v[`PGM_F_BUCK1];
        // R2: linreg both edges, own masks
        set_v[`PGM_F_LDO0] = (fall[2] & ~mask_r[`PGM_M_FALL + 2]) |
                             (rise[2] & ~mask_r[`PGM_M_RISE + 2]);
        set_v[`PGM_F_LDO1] = (fall[3] & ~mask_r[`PGM_M_FALL + 3]) |
                             (rise[3] & ~mask_r[`PGM_M_RISE + 3]);
        set_v[`PGM_F_LDOSUM] = set_v[`PGM_F_LDO0] | set_v[`PGM_F_LDO1];
        // R3: power-valid drop
        set_v[`PGM_F_PVDROP] = pv_q_r & ~pv_r & ~mask_r[`PGM_M_PVDROP];
        // R5 R6: clock change, or absent while detector runs
        set_v[`PGM_F_SYNC] = ((sclk ^ sclk_q_r) | (clk_det_enable & ~sclk)) &
                             ~mask_r[`PGM_M_SYNC];
        // R7: measurement ready
        set_v[`PGM_F_MEAS] = meas_done & ~mask_r[`PGM_M_MEAS];
        // R9: reset flag after startup, strap mask
        set_v[`PGM_F_RESET] = boot_r & ~reset_mask_r;
        set_v[`PGM_F_OVP] = ovp;
        set_v[`PGM_F_TSD] = tsd;
    end

    // R24: only written ones clear flags
    generate
        for (g = 0; g < `PGM_NFLAG; g++) begin : g_flag
            pgm_edge_flag u_flag (
                .clk    (clk),
                .srst   (rst_all),
                .set_i  (set_v[g]),
                .clr_i  (wr_flag & pwdata[g]),
                .flag_o (flag_v[g])
            );
        end
    endgenerate

    // boot pulse: one cycle after configuration load
    always_ff @(posedge clk) begin
        if (rst_all) begin
            boot_r   <= 1'b0;
            sclk_q_r <= 1'b0;
        end else begin
            boot_r   <= load_r;
            sclk_q_r <= sclk;
        end
    end

    // R17 R20: fault latch, set wins over write-one clear
    logic             gate_busy;  // gated hold timer running
    logic [NRAIL-1:0] fault_r;
    always_ff @(posedge clk) begin
        if (rst_all) begin
            fault_r <= '0;
        end else begin
            // R18: host write-one clears
            fault_r <= (fault_r & ~(wr_fault ? pwdata[NRAIL-1:0] : '0)) |
                       (rail_sel & ~rail_good & {NRAIL{~gate_busy}});
        end
    end

    // gated hold timer, R16
    pgm_pkg::pgm_state_t st_r;
    logic [GW-1:0] gcnt_r;
    logic          en_q_r;
    wire           any_en = |rail_enable;
    assign gate_busy = (st_r == pgm_pkg::PGM_GATED);
    always_ff @(posedge clk) begin
        if (rst_all) begin
            st_r   <= pgm_pkg::PGM_LOAD;
            gcnt_r <= '0;
            en_q_r <= 1'b0;
        end else begin
            en_q_r <= any_en;
            unique case (st_r)
                pgm_pkg::PGM_LOAD: begin
                    st_r <= pgm_pkg::PGM_RUN;
                end
                pgm_pkg::PGM_RUN: begin
                    // R16: power-up or change starts hold
                    if ((any_en & ~en_q_r) | volt_change_req) begin
                        st_r   <= pgm_pkg::PGM_GATED;
                        gcnt_r <= GW'(GATE_CYC - 1);
                    end
                end
                pgm_pkg::PGM_GATED: begin
                    if (gcnt_r == '0) st_r <= pgm_pkg::PGM_RUN;
                    else              gcnt_r <= gcnt_r - 1'b1;
                end
                default: st_r <= pgm_pkg::PGM_LOAD;
            endcase
        end
    end

    // combined validity
    logic all_ok, pv_nxt;
    logic started_r;  // continuous: a regulator has been enabled
    always_comb begin
        // R12: all selected sources valid
        all_ok = &(rail_good | ~rail_sel) &
                 ~(twarn & ctrl_r[`PGM_C_TWSEL]) &
                 ~flag_v[`PGM_F_OVP] & ~flag_v[`PGM_F_TSD];
        // R21: ramping selected rail forces inactive
        if (|(ramp & rail_sel)) all_ok = 1'b0;
        // R22: pending faults hold inactive when fault gating is on
        if (ctrl_r[`PGM_C_FGATE] & (|fault_r)) all_ok = 1'b0;
        if (!ctrl_r[`PGM_C_MODE]) begin
            // R16 R17: gated, hold during timer, faults block
            if (gate_busy)      pv_nxt = pv_r;
            else if (|fault_r)  pv_nxt = 1'b0;
            else                pv_nxt = all_ok;
        end else begin
            // R19: continuous, drop on first enable then follow
            if (any_en & ~started_r) pv_nxt = 1'b0;
            else if (started_r)      pv_nxt = all_ok;
            else                     pv_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst_all) begin
            pv_r      <= 1'b1;
            pv_q_r    <= 1'b1;
            started_r <= 1'b0;
        end else begin
            pv_q_r <= pv_r;
            if (any_en) started_r <= 1'b1;
            pv_r <= (st_r == pgm_pkg::PGM_LOAD) ? 1'b1 : pv_nxt;
        end
    end

    // R4 R14: polarity and drive type touch only the pin
    // lockout and restart release the pin too, the device is shut down then
    always_ff @(posedge clk) begin
        if (rst_all) begin
            power_valid_out <= 1'b0;
            power_valid_oe  <= 1'b0;
        end else begin
            power_valid_out <= pv_r ~^ ctrl_r[`PGM_C_POL];
            // open drain drives only the low level
            power_valid_oe  <= ~ctrl_r[`PGM_C_OD] | ~(pv_r ~^ ctrl_r[`PGM_C_POL]);
        end
    end

    // R24: irq stays low while any flag pending
    always_ff @(posedge clk) begin
        if (rst_all) irq_line_low <= 1'b1;
        else      irq_line_low <= ~(|flag_v);
    end

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (acc & ~pwrite) begin
            unique case (paddr)
                `PGM_A_FLAGS:  prdata = {20'h0, flag_v};
                `PGM_A_MASKS:  prdata = {20'h0, mask_r};
                `PGM_A_STATUS: prdata = {25'h0, twarn, sclk, pv_r, rail_good};
                `PGM_A_CTRL:   prdata = ctrl_r;
                `PGM_A_FAULT:  prdata = {28'h0, fault_r};
                default:       prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // pgm_power_good

/* File: testbench/pgm_power_good_sva.sv */
`include "pgm_regs.svh"
// pin and bus relations of the power-good block
module pgm_power_good_sva (
    input wire logic        clk,              // clock
    input wire logic        srst,             // sync reset
    input wire logic        psel,             // apb select
    input wire logic        penable,          // apb enable
    input wire logic        pwrite,           // apb write
    input wire logic [11:0] paddr,            // apb address
    input wire logic [31:0] pwdata,           // apb write data
    input wire logic [31:0] prdata,           // apb read data
    input wire logic        pready,           // apb ready
    input wire logic        pslverr,          // apb error
    input wire logic        analog_supply_ok, // supply above lockout
    input wire logic        reset_mask_strap, // reset flag mask strap
    input wire logic        overvolt_in,      // input overvoltage
    input wire logic        power_valid_oe,   // pin drive enable
    input wire logic        irq_line_low,     // interrupt, active low
    input wire logic        soft_reset_req    // restart pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // any write with set bits may clear, unmask or restart, so it excuses irq release
    logic wr_nz;
    logic acc;
    assign acc = psel && penable;
    assign wr_nz = acc && pwrite && (pwdata != 32'h0000_0000);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_lockout_idle: assert property (!analog_supply_ok [*3] |=> irq_line_low && !power_valid_oe)
        else $error("lockout left irq or pin drive active");
    a_reset_flag_up: assert property ($fell(srst) && !reset_mask_strap |-> ##[1:4] !irq_line_low)
        else $error("no reset flag after reset release");
    a_soft_rst_pulse: assert property (acc && pwrite && paddr == `PGM_A_RESET && pwdata[0] |=> soft_reset_req ##1 !soft_reset_req)
        else $error("soft reset request not a single pulse");
    a_soft_rst_flag: assert property (soft_reset_req && !reset_mask_strap && analog_supply_ok |-> ##[1:6] !irq_line_low)
        else $error("no reset flag after soft reset");
    a_irq_holds: assert property (!irq_line_low && analog_supply_ok && !soft_reset_req && !wr_nz && !$past(wr_nz) |=> !irq_line_low)
        else $error("irq released without a clearing write");
    a_fault_irq: assert property (acc && !pwrite && paddr == `PGM_A_FLAGS && prdata[11:10] != 2'b00 |-> ##[0:1] !irq_line_low)
        else $error("unmaskable flag pending but irq idle");
    a_ovp_raises: assert property (!overvolt_in ##1 (overvolt_in && analog_supply_ok) [*6] |-> !irq_line_low)
        else $error("overvoltage did not raise irq");
    a_bus_answer: assert property (acc |-> pready && (pslverr == (paddr > `PGM_A_RESET)))
        else $error("bus answer or error flag wrong");
endmodule // pgm_power_good_sva

bind pgm_power_good pgm_power_good_sva u_sva (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .analog_supply_ok, .reset_mask_strap, .overvolt_in,
    .power_valid_oe, .irq_line_low, .soft_reset_req);

/* File: testbench/pgm_host_model.sv */
// host side of the register bus: one apb transfer at a time
module pgm_host_model (
    input  wire logic        clk,     // bus clock
    output logic             psel,    // select
    output logic             penable, // enable
    output logic             pwrite,  // direction
    output logic [11:0]      paddr,   // byte address
    output logic [31:0]      pwdata,  // write data
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pready,  // ready
    input  wire logic        pslverr  // error
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // clear by write-one: data bits go out unchanged
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // hold everything until ready is seen at an edge
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // pgm_host_model

/* File: testbench/pgm_power_good_tb.sv */
`include "pgm_regs.svh"
module pgm_power_good_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_FL = `PGM_A_FLAGS;
    localparam logic [11:0] A_MK = `PGM_A_MASKS;
    localparam logic [11:0] A_ST = `PGM_A_STATUS;
    localparam logic [11:0] A_CT = `PGM_A_CTRL;
    localparam logic [11:0] A_FT = `PGM_A_FAULT;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;  // compare every bit
    localparam logic [31:0] CONT = 32'h0000_0A0F; // continuous, active high, all rails
    logic clk, srst, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic analog_supply_ok, mode_strap, reset_mask_strap, volt_change_req, thermal_warn_in;
    logic overvolt_in, thermal_sd_in, clk_det_enable, sync_clk_present, meas_done;
    logic power_valid_out, power_valid_oe, irq_line_low, soft_reset_req;
    logic [3:0] rail_enable, rail_under_ok, rail_over_ok, rail_ramping;
    int n_fail, n_compared;
    pgm_power_good #(.GATE_CYC(20)) uut (.clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .analog_supply_ok, .mode_strap,
        .reset_mask_strap, .rail_enable, .rail_under_ok, .rail_over_ok, .rail_ramping,
        .volt_change_req, .thermal_warn_in, .overvolt_in, .thermal_sd_in, .clk_det_enable,
        .sync_clk_present, .meas_done, .power_valid_out, .power_valid_oe, .irq_line_low,
        .soft_reset_req);
    pgm_host_model host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);
    always #10 clk = ~clk;
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask
    // masked read compare; inputs pass two sync flops, so callers settle first
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        host.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(q & m, x);
    endtask
    task automatic t_boot;
        rd(A_FL, 32'h0000_0200, 32'h0000_0200);
        wr(A_FL, 32'h0000_0000);
        rd(A_FL, 32'h0000_0200, 32'h0000_0200);
        rd(A_CT, ALL, 32'h0000_020F);
        host.xfer(1'b0, 12'h020, 32'h0000_0000, q, e);
        chk({q[30:0], e}, 32'h0000_0001);
        wr(A_CT, CONT);
        wr(A_MK, 32'h0000_00F2);
        wr(A_FT, 32'h0000_000F);
        wr(A_FL, 32'h0000_0FFF);
        wt(2);
        chk({31'h0, irq_line_low}, 32'h0000_0001);
    endtask
    // buck0 falls unmasked, buck1 falls masked; rises masked
    task automatic t_buck;
        rail_under_ok <= 4'hC;
        wt(6);
        rd(A_FL, ALL, 32'h0000_0045);
        rd(A_ST, ALL, 32'h0000_000C);
        rail_under_ok <= 4'hF;
        wt(6);
        rd(A_FL, ALL, 32'h0000_0045);
        rd(A_FT, ALL, 32'h0000_0003);
        wr(A_FT, 32'h0000_0001);
        rd(A_FT, ALL, 32'h0000_0002);
        wr(A_FT, 32'h0000_0002);
        wr(A_FL, 32'h0000_0045);
        rd(A_FL, ALL, 32'h0000_0000);
    endtask
    // linreg0: fall masked, rise unmasked
    task automatic t_linreg;
        wr(A_MK, 32'h0000_00B4);
        rail_under_ok <= 4'hB;
        wt(6);
        rd(A_FL, ALL, 32'h0000_0040);
        rail_under_ok <= 4'hF;
        wt(6);
        rd(A_FL, ALL, 32'h0000_0068);
        rail_over_ok <= 4'hD;
        wt(6);
        rd(A_ST, ALL, 32'h0000_001F);
        wr(A_CT, CONT | 32'h0000_0040);
        wt(6);
        rd(A_ST, 32'h0000_0012, 32'h0000_0000);
        rail_over_ok <= 4'hF;
        wr(A_CT, CONT);
        wr(A_FT, 32'h0000_000F);
        wr(A_FL, 32'h0000_0FFF);
    endtask
    task automatic t_pvalid;
        overvolt_in <= 1'b1;
        wt(6);
        rd(A_ST, 32'h0000_0010, 32'h0000_0000);
        chk({power_valid_oe, power_valid_out}, 32'h0000_0002);
        rd(A_FL, 32'h0000_0440, 32'h0000_0440);
        overvolt_in <= 1'b0;
        wt(6);
        rd(A_ST, 32'h0000_0010, 32'h0000_0000);
        wr(A_FL, 32'h0000_0FFF);
        wt(6);
        rd(A_ST, 32'h0000_0010, 32'h0000_0010);
        wr(A_CT, 32'h0000_080F);
        wt(3);
        chk({31'h0, power_valid_out}, 32'h0000_0000);
        rd(A_ST, 32'h0000_0010, 32'h0000_0010);
        wr(A_CT, 32'h0000_1A0F);
        rail_ramping <= 4'h1;
        wt(6);
        rd(A_ST, 32'h0000_0010, 32'h0000_0000);
        rail_ramping <= 4'h0;
        rail_under_ok <= 4'hE;
        wt(6);
        rail_under_ok <= 4'hF;
        wt(6);
        rd(A_ST, 32'h0000_0010, 32'h0000_0000);
        wr(A_FT, 32'h0000_000F);
        wt(4);
        rd(A_ST, 32'h0000_0010, 32'h0000_0010);
        rail_enable <= 4'h7;
        rail_under_ok <= 4'h7;
        wt(6);
        rd(A_ST, 32'h0000_0010, 32'h0000_0010);
        rail_enable <= 4'hF;
        rail_under_ok <= 4'hF;
        wr(A_CT, CONT);
        wr(A_FT, 32'h0000_000F);
        wr(A_FL, 32'h0000_0FFF);
    endtask
    task automatic t_sync_meas;
        clk_det_enable <= 1'b1;
        sync_clk_present <= 1'b1;
        wt(6);
        rd(A_ST, 32'h0000_0020, 32'h0000_0020);
        rd(A_FL, 32'h0000_0080, 32'h0000_0080);
        sync_clk_present <= 1'b0;
        wr(A_FL, 32'h0000_0080);
        wt(6);
        wr(A_FL, 32'h0000_0080);
        wt(2);
        rd(A_FL, 32'h0000_0080, 32'h0000_0080);
        clk_det_enable <= 1'b0;
        wt(6);
        wr(A_FL, 32'h0000_0FFF);
        meas_done <= 1'b1;
        @(posedge clk) meas_done <= 1'b0;
        wt(3);
        rd(A_FL, ALL, 32'h0000_0100);
        wr(A_FL, 32'h0000_0100);
        wr(A_MK, 32'h0000_04F0);
        meas_done <= 1'b1;
        @(posedge clk) meas_done <= 1'b0;
        wt(4);
        rd(A_FL, ALL, 32'h0000_0000);
    endtask
    task automatic t_restart;
        wr(`PGM_A_RESET, 32'h0000_0001);
        wt(6);
        rd(A_CT, ALL, 32'h0000_020F);
        rd(A_FL, 32'h0000_0200, 32'h0000_0200);
        wr(A_FL, 32'h0000_0FFF);
        reset_mask_strap <= 1'b1;
        analog_supply_ok <= 1'b0;
        wt(4);
        chk({31'h0, irq_line_low}, 32'h0000_0001);
        analog_supply_ok <= 1'b1;
        wt(6);
        rd(A_FL, 32'h0000_0200, 32'h0000_0000);
        rd(A_CT, ALL, 32'h0000_020F);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under two thousand cycles
    initial begin
        wt(8000);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {clk, srst, analog_supply_ok, mode_strap, reset_mask_strap} = 5'b01100;
        {volt_change_req, thermal_warn_in, overvolt_in, thermal_sd_in} = 4'h0;
        {clk_det_enable, sync_clk_present, meas_done} = 3'b000;
        {rail_enable, rail_under_ok, rail_over_ok, rail_ramping} = 16'hFFF0;
        n_fail = 0;
        n_compared = 0;
        wt(20);
        srst <= 1'b0;
        wt(10);
        t_boot();
        t_buck();
        t_linreg();
        t_pvalid();
        t_sync_meas();
        t_restart();
        tally_and_finish();
    end
endmodule // pgm_power_good_tb
